// ---- hdl/dpll_mode_pkg.sv ----
// Constants, types and register map for the loop mode controller.
// Assumes a 50 MHz system clock; all cycle counts are derived from it.
`default_nettype none
package dpll_mode_pkg;
	localparam int unsigned SYS_CLK_HZ     = 50_000_000;
	localparam int unsigned SYS_PERIOD_NS  = 1_000_000_000 / SYS_CLK_HZ;

	// Reference period limits per nominal rate, in ns
	localparam int unsigned P16M_MIN_NS = 38;
	localparam int unsigned P16M_MAX_NS = 75;
	localparam int unsigned P8M_MIN_NS  = 63;
	localparam int unsigned P8M_MAX_NS  = 175;
	localparam int unsigned P2M_MIN_NS  = 263;
	localparam int unsigned P2M_MAX_NS  = 712;
	localparam int unsigned P8K_MIN_NS  = 120_000;
	localparam int unsigned P8K_MAX_NS  = 128_000;

	// Least times round up, longest times round down
	localparam logic [12:0] P16M_MIN = 13'((P16M_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [12:0] P16M_MAX = 13'(P16M_MAX_NS / SYS_PERIOD_NS);
	localparam logic [12:0] P8M_MIN  = 13'((P8M_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [12:0] P8M_MAX  = 13'(P8M_MAX_NS / SYS_PERIOD_NS);
	localparam logic [12:0] P2M_MIN  = 13'((P2M_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [12:0] P2M_MAX  = 13'(P2M_MAX_NS / SYS_PERIOD_NS);
	localparam logic [12:0] P8K_MIN  = 13'((P8K_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [12:0] P8K_MAX  = 13'(P8K_MAX_NS / SYS_PERIOD_NS);
	localparam logic [12:0] SCM_TIMEOUT = P8K_MAX + 13'h0001;

	// Coarse rate window and the edge counts it may see per rate
	localparam int unsigned CFM_WINDOW_NS = 30_000;
	localparam logic [10:0] CFM_WINDOW    = 11'(CFM_WINDOW_NS / SYS_PERIOD_NS);
	localparam logic [9:0]  CFM_2M_LO     = 10'(CFM_WINDOW_NS / P2M_MAX_NS);
	localparam logic [9:0]  CFM_2M_HI     = 10'(CFM_WINDOW_NS / P2M_MIN_NS + 1);
	localparam logic [9:0]  CFM_8M_LO     = 10'(CFM_WINDOW_NS / P8M_MAX_NS);
	localparam logic [9:0]  CFM_8M_HI     = 10'(CFM_WINDOW_NS / P8M_MIN_NS + 1);
	localparam logic [9:0]  CFM_16M_LO    = 10'(CFM_WINDOW_NS / P16M_MAX_NS);
	localparam logic [9:0]  CFM_16M_HI    = 10'(CFM_WINDOW_NS / P16M_MIN_NS + 1);

	// Lock hold after dropping to free-run: 0.1 s
	localparam int unsigned LOCK_HOLD_MS     = 100;
	localparam int unsigned LOCK_HOLD_CYCLES = LOCK_HOLD_MS * (SYS_CLK_HZ / 1000);

	// Register byte offsets
	localparam logic [11:0] ADDR_STATUS   = 12'h000;
	localparam logic [11:0] ADDR_INT_STAT = 12'h004;
	localparam logic [11:0] ADDR_INT_MASK = 12'h008;

	// Interrupt bit positions and reset values
	localparam int unsigned IRQ_FREERUN = 0;
	localparam int unsigned IRQ_NORMAL  = 1;
	localparam int unsigned IRQ_FAULT   = 2;
	localparam logic [2:0]  INT_MASK_RST = 3'h0;

	typedef enum logic {
		MODE_FREERUN = 1'b0,
		MODE_NORMAL  = 1'b1
	} mode_t;

	typedef enum logic [1:0] {
		RATE_8K  = 2'b00,
		RATE_2M  = 2'b01,
		RATE_8M  = 2'b10,
		RATE_16M = 2'b11
	} rate_t;

	typedef struct packed {
		logic  rateValid;
		rate_t rate;
		logic  fault;
		logic  lock;
		mode_t mode;
	} status_t;
endpackage : dpll_mode_pkg
`default_nettype wire

// ---- hdl/dpll_mode_state_machine.sv ----
// Mode controller: reference monitors, rate detector, free-run/normal state machine, APB registers.
// Assumes refClkIn is asynchronous to sys_clk and slow enough to be sampled (levels of at least 2 cycles).
//
// Contract
// - Reset enters free-run, outputs follow oscillator
// - Disrupted reference keeps loop in free-run
// - Clean reference moves to normal automatically
// - Fault in normal returns to free-run
// - Normal mode selects reference for output lock
// - Rate detected automatically from measured period
// - Period or coarse-rate failure forces free-run
// - Coarse monitor counts edges over 30 us
// - Any monitor failure drives fault output high
// - Lock held 0.1 s after leaving normal
`default_nettype none
module dpll_mode_state_machine #(
	parameter int unsigned LOCK_HOLD = dpll_mode_pkg::LOCK_HOLD_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        refClkIn,
	output logic             refSelect,
	output logic             freeRun,
	output logic             lock,
	output logic             refFault,
	output logic [1:0]       refRate,
	output logic             irq,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr
);
	logic [2:0]  refSync_r;
	logic        refLvl_r;
	logic        refEdge;
	logic        havePrev_r;
	logic [12:0] periodCnt_r;
	logic        bandOk;
	dpll_mode_pkg::rate_t band;
	dpll_mode_pkg::rate_t rate_r;
	logic        rateValid_r;
	logic        scmFail;
	logic [10:0] winCnt_r;
	logic [10:0] winLen_r;
	logic [9:0]  edgeCnt_r;
	logic        winEnd;
	logic        cfmFail;
	logic        failSeen_r;
	logic        disrupted_r;
	dpll_mode_pkg::mode_t mode_r;
	logic        lock_r;
	logic [22:0] holdCnt_r;
	logic [2:0]  intStat_r;
	logic [2:0]  intMask_r;
	logic [2:0]  intEvt;
	logic [31:0] prdata_r;
	logic        wrAcc;
	dpll_mode_pkg::status_t status;

	// Three-stage sampler; stage 1 feeds only stage 2
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refSync_r <= 3'h0;
		end else begin
			refSync_r <= {refSync_r[1:0], refClkIn};
		end
	end

	// Level accepted only when stages 2 and 3 agree, filtering metastable glitches
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			refLvl_r <= 1'b0;
		end else if (refSync_r[1] == refSync_r[2]) begin
			refLvl_r <= refSync_r[2];
		end
	end
	assign refEdge = (refSync_r[1] == refSync_r[2]) && refSync_r[2] && !refLvl_r;

	// Period classification into the nominal rate bands
	always_comb begin
		bandOk = 1'b1;
		band   = dpll_mode_pkg::RATE_8K;
		if (periodCnt_r >= dpll_mode_pkg::P16M_MIN && periodCnt_r <= dpll_mode_pkg::P16M_MAX) begin
			band = dpll_mode_pkg::RATE_16M;
		end else if (periodCnt_r >= dpll_mode_pkg::P8M_MIN && periodCnt_r <= dpll_mode_pkg::P8M_MAX) begin
			band = dpll_mode_pkg::RATE_8M;
		end else if (periodCnt_r >= dpll_mode_pkg::P2M_MIN && periodCnt_r <= dpll_mode_pkg::P2M_MAX) begin
			band = dpll_mode_pkg::RATE_2M;
		end else if (periodCnt_r >= dpll_mode_pkg::P8K_MIN && periodCnt_r <= dpll_mode_pkg::P8K_MAX) begin
			band = dpll_mode_pkg::RATE_8K;
		end else begin
			bandOk = 1'b0;
		end
	end

	// Single-period monitor: bad period or no edge before the longest period
	assign scmFail = (refEdge && havePrev_r && !bandOk) || (periodCnt_r == dpll_mode_pkg::SCM_TIMEOUT);

	// Period counter saturates one past the timeout so the timeout fires once
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			periodCnt_r <= 13'h0001;
			havePrev_r  <= 1'b0;
		end else if (refEdge) begin
			periodCnt_r <= 13'h0001;
			havePrev_r  <= 1'b1;
		end else if (periodCnt_r <= dpll_mode_pkg::SCM_TIMEOUT) begin
			periodCnt_r <= periodCnt_r + 13'h0001;
		end
	end

	// Rate detector; no software input picks the rate
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rate_r      <= dpll_mode_pkg::RATE_8K;
			rateValid_r <= 1'b0;
		end else if (scmFail) begin
			rateValid_r <= 1'b0;
		end else if (refEdge && havePrev_r) begin
			rate_r      <= band;
			rateValid_r <= 1'b1;
		end
	end

	// Coarse rate window; an 8 kHz reference is slower than the window and is left to the period check
	assign winEnd = (winCnt_r == dpll_mode_pkg::CFM_WINDOW - 11'h001);
	always_comb begin
		cfmFail = 1'b0;
		if (winEnd && rateValid_r) begin
			case (rate_r)
				dpll_mode_pkg::RATE_2M:  cfmFail = edgeCnt_r < dpll_mode_pkg::CFM_2M_LO || edgeCnt_r > dpll_mode_pkg::CFM_2M_HI;
				dpll_mode_pkg::RATE_8M:  cfmFail = edgeCnt_r < dpll_mode_pkg::CFM_8M_LO || edgeCnt_r > dpll_mode_pkg::CFM_8M_HI;
				dpll_mode_pkg::RATE_16M: cfmFail = edgeCnt_r < dpll_mode_pkg::CFM_16M_LO || edgeCnt_r > dpll_mode_pkg::CFM_16M_HI;
				default:                 cfmFail = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			winCnt_r  <= 11'h000;
			edgeCnt_r <= 10'h000;
		end else if (winEnd) begin
			winCnt_r  <= 11'h000;
			edgeCnt_r <= {9'h000, refEdge};
		end else begin
			winCnt_r <= winCnt_r + 11'h001;
			if (refEdge && edgeCnt_r != 10'h3FF) begin
				edgeCnt_r <= edgeCnt_r + 10'h001;
			end
		end
	end

	// Separate count of cycles since the last window end, so the window length can be checked
	always_ff @(posedge sys_clk) begin
		if (reset || winEnd) begin
			winLen_r <= 11'h000;
		end else begin
			winLen_r <= winLen_r + 11'h001;
		end
	end

	// Disruption flag: a failure sets it; a whole clean window with a known rate clears it; set wins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			disrupted_r <= 1'b1;
			failSeen_r  <= 1'b0;
		end else begin
			if (scmFail || cfmFail) begin
				disrupted_r <= 1'b1;
			end else if (winEnd && !failSeen_r && rateValid_r) begin
				disrupted_r <= 1'b0;
			end
			failSeen_r <= scmFail || (failSeen_r && !winEnd); // A period-monitor failure on the window end taints the next window
		end
	end

	// Mode state machine on the registered disruption status
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_r <= dpll_mode_pkg::MODE_FREERUN;
		end else begin
			case (mode_r)
				dpll_mode_pkg::MODE_FREERUN: if (!disrupted_r) mode_r <= dpll_mode_pkg::MODE_NORMAL;
				dpll_mode_pkg::MODE_NORMAL:  if (disrupted_r) mode_r <= dpll_mode_pkg::MODE_FREERUN;
				default:                     mode_r <= dpll_mode_pkg::MODE_FREERUN;
			endcase
		end
	end

	// Lock indicator; phase-window qualification lives in the loop, here it follows the mode
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lock_r    <= 1'b0;
			holdCnt_r <= 23'h000000;
		end else if (mode_r == dpll_mode_pkg::MODE_NORMAL) begin
			lock_r    <= 1'b1;
			holdCnt_r <= 23'(LOCK_HOLD);
		end else if (holdCnt_r > 23'h000001) begin
			holdCnt_r <= holdCnt_r - 23'h000001;
		end else begin
			lock_r    <= 1'b0;
			holdCnt_r <= 23'h000000;
		end
	end

	// Pin outputs; normal mode hands the reference to the oscillator control
	assign refSelect = (mode_r == dpll_mode_pkg::MODE_NORMAL);
	assign freeRun   = (mode_r == dpll_mode_pkg::MODE_FREERUN);
	assign lock      = lock_r;
	assign refFault  = disrupted_r;
	assign refRate   = rate_r;

	// Interrupt events and sticky status; a new event beats a write-one clear
	assign intEvt[dpll_mode_pkg::IRQ_FREERUN] = (mode_r == dpll_mode_pkg::MODE_NORMAL) && disrupted_r;
	assign intEvt[dpll_mode_pkg::IRQ_NORMAL]  = (mode_r == dpll_mode_pkg::MODE_FREERUN) && !disrupted_r;
	assign intEvt[dpll_mode_pkg::IRQ_FAULT]   = scmFail || cfmFail;
	assign wrAcc = psel && penable && pwrite;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			intStat_r <= 3'h0;
		end else if (wrAcc && paddr == dpll_mode_pkg::ADDR_INT_STAT) begin
			intStat_r <= (intStat_r & ~pwdata[2:0]) | intEvt;
		end else begin
			intStat_r <= intStat_r | intEvt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			intMask_r <= dpll_mode_pkg::INT_MASK_RST;
		end else if (wrAcc && paddr == dpll_mode_pkg::ADDR_INT_MASK) begin
			intMask_r <= pwdata[2:0];
		end
	end
	assign irq = |(intStat_r & intMask_r);

	// Read data captured in the setup phase so it is a flop output during access
	assign status = '{rateValid: rateValid_r, rate: rate_r, fault: disrupted_r, lock: lock_r, mode: mode_r};
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				dpll_mode_pkg::ADDR_STATUS:   prdata_r <= {26'h0000000, status};
				dpll_mode_pkg::ADDR_INT_STAT: prdata_r <= {29'h00000000, intStat_r};
				dpll_mode_pkg::ADDR_INT_MASK: prdata_r <= {29'h00000000, intMask_r};
				default:                      prdata_r <= 32'h00000000;
			endcase
		end
	end
	assign prdata  = prdata_r;
	assign pready  = 1'b1; // Zero wait states
	assign pslverr = psel && penable && paddr != dpll_mode_pkg::ADDR_STATUS &&
		paddr != dpll_mode_pkg::ADDR_INT_STAT && paddr != dpll_mode_pkg::ADDR_INT_MASK;

	// Checks
	a_reset_freerun: assert property (@(posedge sys_clk) reset |=> mode_r == dpll_mode_pkg::MODE_FREERUN && !lock_r)
		else $error("mode not free-run after reset");
	a_stay_free: assert property (@(posedge sys_clk) disable iff (reset) disrupted_r |=> mode_r == dpll_mode_pkg::MODE_FREERUN)
		else $error("left free-run while disrupted");
	a_auto_normal: assert property (@(posedge sys_clk) disable iff (reset)
		(!disrupted_r && mode_r == dpll_mode_pkg::MODE_FREERUN) |=> mode_r == dpll_mode_pkg::MODE_NORMAL)
		else $error("no move to normal on clean reference");
	a_fault_return: assert property (@(posedge sys_clk) disable iff (reset)
		(mode_r == dpll_mode_pkg::MODE_NORMAL && (scmFail || cfmFail)) |=> ##1 freeRun && !refSelect)
		else $error("failure did not force free-run");
	a_rate_detect: assert property (@(posedge sys_clk) disable iff (reset)
		(refEdge && havePrev_r && periodCnt_r >= dpll_mode_pkg::P8M_MIN && periodCnt_r <= dpll_mode_pkg::P8M_MAX)
		|=> rate_r == dpll_mode_pkg::RATE_8M && rateValid_r)
		else $error("rate not detected");
	a_cfm_window: assert property (@(posedge sys_clk) disable iff (reset)
		winEnd == (winLen_r == 11'(dpll_mode_pkg::CFM_WINDOW_NS / dpll_mode_pkg::SYS_PERIOD_NS - 1)))
		else $error("coarse window length wrong");
	a_fault_pin: assert property (@(posedge sys_clk) disable iff (reset)
		(scmFail || cfmFail) |=> refFault [*2])
		else $error("fault output not raised");
	a_lock_hold: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(refSelect) |-> lock [*8])
		else $error("lock dropped early");
	a_lock_drop: assert property (@(posedge sys_clk) disable iff (reset)
		(freeRun && holdCnt_r == 23'h000001) |=> !lock)
		else $error("lock not dropped after hold");
	a_sync_agree: assert property (@(posedge sys_clk) disable iff (reset)
		$changed(refLvl_r) |-> $past(refSync_r[1]) == $past(refSync_r[2]))
		else $error("level changed without agreement");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
		(intEvt[dpll_mode_pkg::IRQ_FAULT] && intMask_r[dpll_mode_pkg::IRQ_FAULT] &&
		!(wrAcc && paddr == dpll_mode_pkg::ADDR_INT_MASK)) |=> irq)
		else $error("masked-in event gave no interrupt");
endmodule : dpll_mode_state_machine
`default_nettype wire

// ---- sim/ref_clk_source.sv ----
// Model of the network timing source that feeds the reference clock.
// Assumes the bench sets halfNs before it raises run; the clock rests low while stopped.
`default_nettype none
module ref_clk_source (
	input  wire logic        run,
	input  wire logic [31:0] halfNs,
	output logic             refClk
);
	timeunit 1ns;
	timeprecision 1ps;

	// Toggles only inside a run, so a stopped source is a real loss of clock
	always begin
		refClk = 1'h0;
		wait (run);
		#3.7; // Phase offset unrelated to the system clock
		while (run) begin // Nominal rate picked by the bench
			#(halfNs) refClk = 1'h1;
			#(halfNs) refClk = 1'h0;
		end
	end
endmodule : ref_clk_source
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the loop mode controller: reference rates, mode changes, lock hold, registers.
// Assumes the design package is compiled first and the source model sits in its own file.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned LOCK_HOLD = 64; // Short hold keeps the run brief
	localparam int unsigned CEIL      = 90000;

	logic        sys_clk = 1'h0;
	logic        reset   = 1'h1;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic        run     = 1'h0;
	logic [31:0] halfNs  = 32'h50;
	logic        refClkIn, refSelect, freeRun, lock, refFault, irq, pready, pslverr, err;
	logic [1:0]  refRate;
	logic [31:0] prdata, rd;
	int unsigned n_fail = 0;
	int unsigned checked = 0;
	int unsigned cycles = 0;
	int unsigned per;

	dpll_mode_state_machine #(.LOCK_HOLD(LOCK_HOLD)) uut (
		.sys_clk(sys_clk), .reset(reset), .refClkIn(refClkIn), .refSelect(refSelect),
		.freeRun(freeRun), .lock(lock), .refFault(refFault), .refRate(refRate), .irq(irq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr)
	);
	ref_clk_source refSrc (.run(run), .halfNs(halfNs), .refClk(refClkIn));

	// 50 MHz system clock
	always #10 sys_clk = ~sys_clk;

	// Hang guard: a run past the ceiling is a failure
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == CEIL) begin
			n_fail++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
			output logic [31:0] rdv, output logic errv);
		@(posedge sys_clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'h1;
		// No wait-state count assumed; only the hang guard ends a stuck wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'h1);
		rdv = prdata;
		errv = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Bounded wait for freeRun (0), refFault (1) or lock (2) to reach a level
	task automatic waitOut(input int sel, input logic val, input int unsigned lim);
		int unsigned n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while ((sel == 0 ? freeRun : sel == 1 ? refFault : lock) !== val && n < lim);
	endtask : waitOut

	// Rate code expected for a reference period; 8.192 MHz band checked first
	function automatic logic [31:0] expRate(input int unsigned perNs);
		if (perNs >= dpll_mode_pkg::P8M_MIN_NS && perNs <= dpll_mode_pkg::P8M_MAX_NS)
			return 32'(dpll_mode_pkg::RATE_8M);
		if (perNs >= dpll_mode_pkg::P2M_MIN_NS && perNs <= dpll_mode_pkg::P2M_MAX_NS)
			return 32'(dpll_mode_pkg::RATE_2M);
		return 32'(dpll_mode_pkg::RATE_8K);
	endfunction : expRate

	task automatic results();
		$display("Counts: %0d checks, %0d mismatches", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	initial begin
		void'($urandom(32'h42F7DB7D));
		repeat (3) @(posedge sys_clk);
		reset <= 1'h0;
		@(negedge sys_clk);
		chk("freeRun", 32'h1, 32'(freeRun));
		chk("refSelect", 32'h0, 32'(refSelect));
		chk("refFault", 32'h1, 32'(refFault));
		chk("irq", 32'h0, 32'(irq));
		apb(1'h0, dpll_mode_pkg::ADDR_STATUS, 32'h0, rd, err);
		chk("status", 32'h4, rd);
		apb(1'h0, dpll_mode_pkg::ADDR_INT_MASK, 32'h0, rd, err);
		chk("intMask", 32'h0, rd);
		apb(1'h1, 12'h00C, $urandom(), rd, err);
		chk("pslverrWr", 32'h1, 32'(err));
		apb(1'h0, 12'h00C, 32'h0, rd, err);
		chk("unmapped", 32'h0, rd);
		chk("pslverrRd", 32'h1, 32'(err));
		$display("Test reset and registers done");
		// 8.192 MHz at 160 ns, a random 2.048 MHz period, then 8 kHz
		for (int i = 0; i < 3; i++) begin
			per = (i == 0) ? 160 : (i == 1) ? 2 * (150 + $urandom_range(190, 0)) : 125000;
			@(posedge sys_clk);
			halfNs <= per / 2;
			run    <= 1'h1;
			waitOut(0, 1'h0, 30000);
			chk("freeRun", 32'h0, 32'(freeRun));
			chk("refSelect", 32'h1, 32'(refSelect));
			chk("refRate", expRate(per), 32'(refRate));
			chk("refFault", 32'h0, 32'(refFault));
			waitOut(2, 1'h1, 200);
			chk("lock", 32'h1, 32'(lock));
			chk("irqMasked", 32'h0, 32'(irq));
			apb(1'h0, dpll_mode_pkg::ADDR_INT_STAT, 32'h0, rd, err);
			chk("intNormal", 32'h1, 32'(rd[dpll_mode_pkg::IRQ_NORMAL]));
			apb(1'h1, dpll_mode_pkg::ADDR_INT_MASK, 32'h2, rd, err);
			@(negedge sys_clk);
			chk("irqOn", 32'h1, 32'(irq));
			apb(1'h1, dpll_mode_pkg::ADDR_INT_STAT, 32'h7, rd, err);
			@(negedge sys_clk);
			chk("irqClr", 32'h0, 32'(irq));
			// Only the monitor-failure interrupt is let through while the clock is lost
			apb(1'h1, dpll_mode_pkg::ADDR_INT_MASK, 32'h4, rd, err);
			// Loss of clock: a period or coarse-rate monitor must trip
			@(posedge sys_clk);
			run <= 1'h0;
			waitOut(1, 1'h1, 14000);
			chk("refFault", 32'h1, 32'(refFault));
			chk("irqFault", 32'h1, 32'(irq));
			waitOut(0, 1'h1, 10);
			chk("freeRun", 32'h1, 32'(freeRun));
			chk("lockHeld", 32'h1, 32'(lock));
			repeat (LOCK_HOLD + 8) @(negedge sys_clk);
			chk("lockDrop", 32'h0, 32'(lock));
			chk("stayFree", 32'h1, 32'(freeRun));
			// Mask off again so the next rate starts with the interrupt quiet
			apb(1'h1, dpll_mode_pkg::ADDR_INT_MASK, 32'h0, rd, err);
			$display("Test rate %0d done", i);
		end
		results();
	end
endmodule : tb
`default_nettype wire
